// ### rtl/gtcsr_pkg.sv
// Purpose: constants for the guest translation register bank
// Assumes: 64-bit hypervisor word width by default
// Notes: field layouts for both word widths
package gtcsr_pkg;
	localparam int GTCSR_XLEN = 64;
	// 64-bit layout
	localparam int GTCSR_MODE64_LSB = 60;
	localparam int GTCSR_MODE64_W = 4;
	localparam int GTCSR_ZERO64_LSB = 58;
	localparam int GTCSR_TAG64_LSB = 44;
	localparam int GTCSR_TAG64_W = 14;
	localparam int GTCSR_PPN64_W = 44;
	// 32-bit layout
	localparam int GTCSR_MODE32_LSB = 31;
	localparam int GTCSR_TAG32_LSB = 22;
	localparam int GTCSR_TAG32_W = 9;
	localparam int GTCSR_PPN32_W = 22;
	// tag limits per scheme
	localparam int GTCSR_TAG_LIMIT_34 = 7;
	localparam int GTCSR_TAG_LIMIT_WIDE = 14;
	// scheme encodings
	localparam logic [3:0] GTCSR_MODE_BARE = 4'h0;
	localparam logic [3:0] GTCSR_MODE_P34 = 4'h1;
	localparam logic [3:0] GTCSR_MODE_P41 = 4'h8;
	localparam logic [3:0] GTCSR_MODE_P50 = 4'h9;
	localparam logic [3:0] GTCSR_MODE_P59 = 4'hA;
	// privilege encodings
	localparam logic [1:0] GTCSR_PRIV_U = 2'h0;
	localparam logic [1:0] GTCSR_PRIV_S = 2'h1;
	// reset values (none documented; zero chosen)
	localparam logic [63:0] GTCSR_RESET_VAL = 64'h0000000000000000;
	// trap-instruction info kinds
	typedef enum logic [1:0] {
		GTCSR_TI_ZERO = 2'b00,
		GTCSR_TI_INSN = 2'b01,
		GTCSR_TI_PTW = 2'b10
	} gtcsr_tinfo_t;
	// pseudo-instruction written for an implicit first-stage table access
	localparam logic [63:0] GTCSR_TI_PTW_READ = 64'h0000000000002000;
	localparam logic [63:0] GTCSR_TI_PTW_WRITE = 64'h0000000000002020;
endpackage

// ### rtl/gtcsr_bank.sv
// Purpose: guest translation control and trap instruction info registers
// Assumes: hart pipeline presents one access per cycle on the csr port
// Notes: fields write-any-read-legal; values legalised on the write path
`timescale 1ns/1ps
// Functional notes
// - trap into HS writes zero or instruction info
// - trap info keeps only hardware-writable values
// - 64-bit layout: mode, zeros, tag, frame
// - trap-vm bit makes HS access illegal
// - 32-bit: mode 0 bare, 1 paged 34
// - 64-bit: modes 0, 8, 9, 10 defined
// - bare: guest addresses pass through untranslated
// - only a subset of paged modes needed
// - unsupported mode write legalises each field
// - paged modes read frame bits 1:0 zero
// - frame bits 1:0 may be hardwired zero
// - tag bits low, contiguous, all writable
// - written ones read back only where implemented
// - tag width capped at 7 or 14
// - implicit table fault marked in trap info
module gtcsr_bank import gtcsr_pkg::*; #(
	parameter int XLEN = GTCSR_XLEN,
	parameter int TAG_BITS = 14,
	parameter bit HAS_P41 = 1'b1,
	parameter bit HAS_P50 = 1'b1,
	parameter bit HAS_P59 = 1'b0
) (
	input wire logic mclk, // hart clock
	input wire logic arst_n, // async reset
	input wire logic clk_en, // freezes state when low
	input wire logic csr_req, // access to one of the two registers
	input wire logic csr_sel_info, // 1 trap info, 0 translation control
	input wire logic csr_we, // write (else read)
	input wire logic [XLEN-1:0] csr_wdata, // write data
	input wire logic [1:0] priv_mode, // effective privilege
	input wire logic virt_mode, // guest mode active
	input wire logic trap_virtual_memory, // machine-status trap bit
	input wire logic user_hypervisor_access, // hypervisor-status user bit
	output logic [XLEN-1:0] csr_rdata, // read data
	output logic csr_illegal, // illegal-instruction on this access
	input wire logic trap_take, // trap taken into HS this cycle
	input wire gtcsr_tinfo_t trap_kind, // what to deposit
	input wire logic [31:0] trap_insn, // transformed trapping instruction
	input wire logic trap_ptw_write, // implicit access was a write
	output logic [3:0] gt_mode, // active scheme
	output logic [TAG_BITS-1:0] guest_machine_tag, // tag for translation
	output logic [43:0] root_frame_number, // root frame
	output logic gt_active, // register active for translation
	output logic gt_bare // no translation; pmp only
);

	localparam int MW = (XLEN == 64) ? GTCSR_MODE64_W : 1;
	localparam int TW = (XLEN == 64) ? GTCSR_TAG64_W : GTCSR_TAG32_W;
	localparam int PW = (XLEN == 64) ? GTCSR_PPN64_W : GTCSR_PPN32_W;
	localparam int TML = (XLEN == 64) ? GTCSR_TAG_LIMIT_WIDE : GTCSR_TAG_LIMIT_34;
	localparam int TB = (TAG_BITS > TML) ? TML : TAG_BITS;
	localparam int ML = (XLEN == 64) ? GTCSR_MODE64_LSB : GTCSR_MODE32_LSB;
	localparam int TL = (XLEN == 64) ? GTCSR_TAG64_LSB : GTCSR_TAG32_LSB;

	////////////////////////////////////////////////////////////////////////
	// legalisation helpers

	function automatic logic mode_ok(input logic [3:0] m);
		if (XLEN == 64)
			mode_ok = (m == GTCSR_MODE_BARE) || (HAS_P41 && m == GTCSR_MODE_P41) ||
				(HAS_P50 && m == GTCSR_MODE_P50) || (HAS_P59 && m == GTCSR_MODE_P59);
		else
			mode_ok = (m == GTCSR_MODE_BARE) || (m == GTCSR_MODE_P34);
	endfunction

	function automatic logic [TW-1:0] tag_mask();
		logic [TW-1:0] k;
		k = '0;
		for (int i = 0; i < TB; i++)
			k[i] = 1'b1;
		tag_mask = k;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	logic [3:0] mode_r;
	logic [3:0] mode_nxt;
	logic [TW-1:0] tag_r;
	logic [TW-1:0] tag_nxt;
	logic [PW-1:0] ppn_r;
	logic [PW-1:0] ppn_nxt;
	logic [XLEN-1:0] info_r;
	logic [XLEN-1:0] info_nxt;
	logic [XLEN-1:0] rdata_nxt;

	wire hs_mode = (priv_mode == GTCSR_PRIV_S) && !virt_mode;
	wire acc_illegal = csr_req && !csr_sel_info && hs_mode && trap_virtual_memory;
	wire ctl_wr = csr_req && csr_we && !csr_sel_info && !acc_illegal;
	wire info_wr = csr_req && csr_we && csr_sel_info;

	wire [3:0] wr_mode = (XLEN == 64) ? 4'(csr_wdata[ML +: MW]) : {3'h0, csr_wdata[ML]};
	wire [TW-1:0] wr_tag = csr_wdata[TL +: TW];
	wire [PW-1:0] wr_ppn = csr_wdata[PW-1:0];

	// unsupported mode keeps old mode but other fields still update
	wire [3:0] legal_mode = mode_ok(wr_mode) ? wr_mode : mode_r;
	wire [TW-1:0] legal_tag = wr_tag & tag_mask();
	wire [PW-1:0] legal_ppn = {wr_ppn[PW-1:2], 2'b00};

	assign mode_nxt = ctl_wr ? legal_mode : mode_r;
	assign tag_nxt = ctl_wr ? legal_tag : tag_r;
	assign ppn_nxt = ctl_wr ? legal_ppn : ppn_r;

	////////////////////////////////////////////////////////////////////////
	// trap instruction info

	wire [XLEN-1:0] ptw_val = trap_ptw_write ? XLEN'(GTCSR_TI_PTW_WRITE) :
		XLEN'(GTCSR_TI_PTW_READ);
	wire [XLEN-1:0] insn_val = {{(XLEN-32){1'b0}}, trap_insn[31:1], 1'b0};
	wire [XLEN-1:0] trap_val = (trap_kind == GTCSR_TI_PTW) ? ptw_val :
		(trap_kind == GTCSR_TI_INSN) ? insn_val : '0;
	// software writes kept only where hardware could have put them
	wire [XLEN-1:0] info_legal = ((csr_wdata == XLEN'(GTCSR_TI_PTW_READ)) ||
		(csr_wdata == XLEN'(GTCSR_TI_PTW_WRITE))) ? csr_wdata :
		{{(XLEN-32){1'b0}}, csr_wdata[31:1], 1'b0};

	// trap deposit wins over a same-cycle software write
	assign info_nxt = trap_take ? trap_val : (info_wr ? info_legal : info_r);

	////////////////////////////////////////////////////////////////////////
	// read path

	wire [XLEN-1:0] ctl_word;
	generate
		if (XLEN == 64) begin : g_w64
			assign ctl_word = {mode_r, 2'b00, tag_r, ppn_r};
		end else begin : g_w32
			assign ctl_word = {mode_r[0], tag_r, ppn_r};
		end
	endgenerate

	assign rdata_nxt = (!csr_req || csr_we || acc_illegal) ? csr_rdata :
		(csr_sel_info ? info_r : ctl_word);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode_r <= GTCSR_RESET_VAL[3:0];
			tag_r <= '0;
			ppn_r <= '0;
			info_r <= '0;
			csr_rdata <= '0;
			csr_illegal <= 1'b0;
		end else if (clk_en) begin
			mode_r <= mode_nxt;
			tag_r <= tag_nxt;
			ppn_r <= ppn_nxt;
			info_r <= info_nxt;
			csr_rdata <= rdata_nxt;
			csr_illegal <= acc_illegal;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// translation outputs

	assign gt_mode = mode_r;
	assign guest_machine_tag = TAG_BITS'(tag_r);
	assign root_frame_number = 44'(ppn_r);
	assign gt_active = !((priv_mode == GTCSR_PRIV_U) && !user_hypervisor_access);
	assign gt_bare = (mode_r == GTCSR_MODE_BARE);

	// are software duties; bare with nonzero fields is stored as written, except frame bits 1:0 and unimplemented tag bits, which are cleared.

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	sequence s_hs_trapped_acc;
		csr_req && !csr_sel_info && hs_mode && trap_virtual_memory && clk_en;
	endsequence

	tvm_illegal_a: assert property (s_hs_trapped_acc |=> csr_illegal)
		else $error("trapped control access not flagged");
	tvm_nowrite_a: assert property (s_hs_trapped_acc |=> $stable(ppn_r) && $stable(tag_r))
		else $error("trapped control access changed state");
	frame_low_a: assert property (ppn_r[1:0] == 2'b00)
		else $error("frame low bits nonzero");
	tag_impl_a: assert property ((tag_r & ~tag_mask()) == '0)
		else $error("unimplemented tag bit set");
	mode_legal_a: assert property (mode_ok(mode_r))
		else $error("illegal scheme stored");
	field_wr_a: assert property (ctl_wr && clk_en |=> tag_r == $past(legal_tag))
		else $error("tag not legalised individually");
	trap_info_a: assert property (trap_take && clk_en && trap_kind == GTCSR_TI_ZERO
		|=> info_r == '0)
		else $error("trap info not cleared");
	ptw_info_a: assert property (trap_take && clk_en && trap_kind == GTCSR_TI_PTW
		|=> info_r[13] && info_r[0] == 1'b0)
		else $error("implicit access not marked");
	active_user_a: assert property (priv_mode == GTCSR_PRIV_U && !user_hypervisor_access
		|-> !gt_active)
		else $error("active in user mode");

	////////////////////////////////////////////////////////////////////////
	// access steps

	sequence s_ctl_write;
		ctl_wr && clk_en;
	endsequence

	sequence s_ctl_read;
		csr_req && !csr_we && !csr_sel_info && !acc_illegal && clk_en;
	endsequence

	sequence s_info_read;
		csr_req && !csr_we && csr_sel_info && clk_en;
	endsequence

	sequence s_info_sw_write;
		info_wr && !trap_take && clk_en;
	endsequence

	sequence s_trap_insn;
		trap_take && clk_en && trap_kind == GTCSR_TI_INSN;
	endsequence

	sequence s_trap_ptw;
		trap_take && clk_en && trap_kind == GTCSR_TI_PTW;
	endsequence

	sequence s_frozen;
		!clk_en;
	endsequence

	////////////////////////////////////////////////////////////////////////
	// write path checks

	mode_wr_a: assert property (s_ctl_write |=> mode_r == $past(legal_mode))
		else $error("scheme not legalised on write");
	ppn_wr_a: assert property (s_ctl_write |=> ppn_r == $past(legal_ppn))
		else $error("frame not legalised on write");
	mode_keep_a: assert property (ctl_wr && clk_en && !mode_ok(wr_mode)
		|=> mode_r == $past(mode_r))
		else $error("unsupported scheme stored");
	zero_bits_a: assert property ((XLEN != 64) || (ctl_word[ML-1 -: 2] == 2'b00))
		else $error("reserved zero bits set");
	tag_cap_a: assert property ((tag_r >> TML) == '0)
		else $error("tag wider than limit");
	out_frame_a: assert property (root_frame_number[1:0] == 2'b00)
		else $error("frame output low bits nonzero");
	ctl_hold_a: assert property (!ctl_wr && clk_en
		|=> $stable(mode_r) && $stable(tag_r) && $stable(ppn_r))
		else $error("control fields moved without write");

	////////////////////////////////////////////////////////////////////////
	// read path checks

	ctl_read_a: assert property (s_ctl_read |=> csr_rdata == $past(ctl_word))
		else $error("control read data wrong");
	info_read_a: assert property (s_info_read |=> csr_rdata == $past(info_r))
		else $error("trap info read data wrong");
	illegal_rdata_a: assert property (s_hs_trapped_acc |=> $stable(csr_rdata))
		else $error("trapped access changed read data");
	illegal_mode_a: assert property (s_hs_trapped_acc |=> $stable(mode_r))
		else $error("trapped access changed scheme");
	legal_acc_a: assert property (csr_req && clk_en && !acc_illegal
		|=> !csr_illegal)
		else $error("legal access flagged");
	info_open_a: assert property (csr_req && csr_sel_info && clk_en |=> !csr_illegal)
		else $error("trap info access flagged");

	////////////////////////////////////////////////////////////////////////
	// trap deposit checks

	trap_wins_a: assert property (trap_take && clk_en |=> info_r == $past(trap_val))
		else $error("trap deposit lost");
	trap_insn_a: assert property (s_trap_insn |=> info_r == $past(insn_val))
		else $error("instruction info wrong");
	insn_bit0_a: assert property (s_trap_insn |=> info_r[0] == 1'b0)
		else $error("instruction info bit 0 set");
	ptw_val_a: assert property (s_trap_ptw |=> info_r == $past(ptw_val))
		else $error("implicit access value wrong");
	info_write_a: assert property (s_info_sw_write |=> info_r == $past(info_legal))
		else $error("trap info write not legalised");
	info_hold_a: assert property (!trap_take && !info_wr && clk_en
		|=> $stable(info_r))
		else $error("trap info moved without cause");

	////////////////////////////////////////////////////////////////////////
	// translation output checks

	active_priv_a: assert property (priv_mode != GTCSR_PRIV_U |-> gt_active)
		else $error("inactive outside user mode");
	active_hu_a: assert property (user_hypervisor_access |-> gt_active)
		else $error("inactive with user access set");
	bare_out_a: assert property (gt_bare |-> gt_mode == GTCSR_MODE_BARE)
		else $error("bare flag without bare scheme");
	freeze_a: assert property (s_frozen |=> $stable(mode_r) && $stable(tag_r)
		&& $stable(ppn_r) && $stable(info_r))
		else $error("state moved while frozen");

endmodule // gtcsr_bank

// ### bench/gtcsr_hart_model.sv
// Purpose: hart trap side driving trap deposits into the bank
// Assumes: one trap per call, pulse lasts one clock
// Notes: insn bus scrambled once the pulse is over
`timescale 1ns/1ps
module gtcsr_hart_model import gtcsr_pkg::*; (
	input wire logic mclk, // hart clock
	output logic trap_take, // trap pulse
	output gtcsr_tinfo_t trap_kind, // deposit kind
	output logic [31:0] trap_insn, // trapping instruction
	output logic trap_ptw_write // implicit access was a write
);
	initial begin
		trap_take = 1'b0;
		trap_kind = GTCSR_TI_ZERO;
		trap_insn = 32'h0;
		trap_ptw_write = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	task automatic trap(input gtcsr_tinfo_t k, input logic [31:0] i, input logic w);
		@(posedge mclk);
		#1 trap_take = 1'b1;
		trap_kind = k;
		trap_insn = i;
		trap_ptw_write = w;
		@(posedge mclk);
		#1 trap_take = 1'b0;
		trap_insn = ~i;
		trap_ptw_write = ~w;
	endtask
endmodule // gtcsr_hart_model

// ### bench/guest_translation_csrs_tb_top.sv
// Purpose: self-checking bench for the guest translation registers
// Assumes: 64-bit word, modes 0, 8, 9 supported, 14 tag bits
// Notes: accesses one at a time through the csr port
`timescale 1ns/1ps
module guest_translation_csrs_tb_top import gtcsr_pkg::*;;
	logic mclk = 0, arst_n = 0, clk_en = 1, csr_req = 0, csr_sel_info = 0, csr_we = 0;
	logic [63:0] csr_wdata = 0, csr_rdata, rd, ex;
	logic [1:0] priv_mode = GTCSR_PRIV_S;
	logic virt_mode = 0, trap_virtual_memory = 0, user_hypervisor_access = 0, ill;
	logic csr_illegal, trap_take, trap_ptw_write, gt_active, gt_bare;
	gtcsr_tinfo_t trap_kind;
	logic [31:0] trap_insn;
	logic [3:0] gt_mode, em;
	logic [13:0] guest_machine_tag;
	logic [43:0] root_frame_number;
	int failures = 0, total_checks = 0;
	gtcsr_bank dut_u (.mclk, .arst_n, .clk_en, .csr_req, .csr_sel_info, .csr_we,
		.csr_wdata, .priv_mode, .virt_mode, .trap_virtual_memory, .user_hypervisor_access,
		.csr_rdata, .csr_illegal, .trap_take, .trap_kind, .trap_insn, .trap_ptw_write,
		.gt_mode, .guest_machine_tag, .root_frame_number, .gt_active, .gt_bare);
	gtcsr_hart_model hart_u (.mclk, .trap_take, .trap_kind, .trap_insn, .trap_ptw_write);
	always #5 mclk = ~mclk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [63:0] e, g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic acc(input logic s, w, input logic [63:0] d);
		@(posedge mclk);
		#1 csr_req = 1;
		csr_sel_info = s;
		csr_we = w;
		csr_wdata = d;
		@(posedge mclk);
		#1 csr_req = 0;
		rd = csr_rdata;
		ill = csr_illegal;
	endtask
	task automatic summarize();
		if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#100000 failures++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge mclk);
		#1 arst_n = 1;
		acc(0, 0, 0);
		chk("reset", 64'h0, rd);
		acc(0, 1, {4'h8, 60'hFFFFFFFFFFFFFFF});
		acc(0, 0, 0);
		chk("layout", 64'h83FFFFFFFFFFFFFC, rd);
		chk("gmode", 64'h8, 64'(gt_mode));
		chk("gtag", 64'h3FFF, 64'(guest_machine_tag));
		chk("gframe", 64'hFFFFFFFFFFC, 64'(root_frame_number));
		em = 4'h8;
		for (int m = 0; m < 16; m++) begin
			if (m == 0 || m == 8 || m == 9) em = 4'(m);
			acc(0, 1, {4'(m), 60'h0});
			acc(0, 0, 0);
			chk("mode", {em, 60'h0}, rd);
			chk("bare", 64'(em == 0), 64'(gt_bare));
		end
		acc(0, 1, 64'hA000500000000100);
		acc(0, 0, 0);
		chk("unsup", 64'h9000500000000100, rd);
		trap_virtual_memory = 1;
		acc(0, 1, 0);
		chk("illw", 1, 64'(ill));
		acc(0, 0, 0);
		chk("illr", 1, 64'(ill));
		chk("illrd", 64'h9000500000000100, rd);
		acc(1, 0, 0);
		chk("infoacc", 0, 64'(ill));
		trap_virtual_memory = 0;
		acc(0, 0, 0);
		chk("nowrite", 64'h9000500000000100, rd);
		hart_u.trap(GTCSR_TI_INSN, 32'h00A32023, 0);
		acc(1, 0, 0);
		chk("tinsn", 64'h00A32022, rd);
		hart_u.trap(GTCSR_TI_PTW, 0, 1);
		acc(1, 0, 0);
		chk("tptww", 64'h2020, rd);
		hart_u.trap(GTCSR_TI_PTW, 0, 0);
		acc(1, 0, 0);
		chk("tptwr", 64'h2000, rd);
		hart_u.trap(GTCSR_TI_ZERO, 32'hFFFF, 0);
		acc(1, 0, 0);
		chk("tzero", 64'h0, rd);
		acc(1, 1, 64'hFFFFFFFFFFFFFFFF);
		acc(1, 0, 0);
		chk("infolegal", 64'hFFFFFFFE, rd);
		clk_en = 0;
		acc(1, 1, 64'h2000);
		clk_en = 1;
		acc(1, 0, 0);
		chk("freeze", 64'hFFFFFFFE, rd);
		priv_mode = GTCSR_PRIV_U;
		#1 chk("act_u0", 0, 64'(gt_active));
		user_hypervisor_access = 1;
		#1 chk("act_u1", 1, 64'(gt_active));
		summarize();
	end
endmodule // guest_translation_csrs_tb_top
